/* hw/sep_pkg.sv */
// Purpose: Shared constants and types for the serial EEPROM command and protection block
// Assumes: Serial link in mode 0, system clock at 200 MHz
// Notes: Behaviour list below uses the tags found in the design
//
// Behaviour
// - Deselected: ignore input, output high impedance
// - Sample input bits on rising serial clock
// - Change output only after falling serial clock
// - Pause with hold, keep sequence state
// - While paused ignore inputs, output high impedance
// - Frame starts on select; 8-bit opcode, MSB first
// - Decode set and clear write latch opcodes
// - Decode status read and status write opcodes
// - Decode array read and array write opcodes
// - Write latch clear at power-up
// - Clear latch command blocks all programming
// - Status bit 0 shows write in progress
// - Status bit 1 mirrors the write latch
// - Bits 4-6 zero; all ones while busy
// - Block protect bits select protected range
// - Protect bits held like array cells; here rst_in loads BP_RESET into them, while array cells keep their contents
// - Hardware protection blocks all status writes
// - Protect enable low ignores protect pin
// - Protect pin fall never aborts running write
// - Enable bit not clearable while protected
// - Protected blocks never written; latch required
// - 32 pages of 32 bytes, 10-bit address
// - While busy only status read acts
// - Write latch clears when write finishes
// - Array read increments and wraps address
// - Page write wraps within five address bits
package sep_pkg;

	// Array geometry
	localparam int ADDR_W = 10;
	localparam int PAGE_W = 5;
	localparam int PAGE_BYTES = 32;
	localparam int MEM_BYTES = 1024;

	// Opcode fields: upper nibble zero, bit 3 ignored, low three bits select
	localparam logic [2:0] OP_SET_LATCH = 3'h6;
	localparam logic [2:0] OP_CLR_LATCH = 3'h4;
	localparam logic [2:0] OP_STAT_RD = 3'h5;
	localparam logic [2:0] OP_STAT_WR = 3'h1;
	localparam logic [2:0] OP_ARRAY_RD = 3'h3;
	localparam logic [2:0] OP_ARRAY_WR = 3'h2;

	// Status byte layout
	localparam int ST_BUSY = 0;
	localparam int ST_LATCH = 1;
	localparam int ST_BP_LO = 2;
	localparam int ST_BP_HI = 3;
	localparam int ST_HWP_EN = 7;
	localparam logic [7:0] STAT_BUSY_VAL = 8'hff;

	// Values at power-up of the protection cells and the latch
	localparam logic [1:0] BP_RESET = 2'h0;
	localparam logic HWP_EN_RESET = 1'b0;
	localparam logic LATCH_RESET = 1'b0;

	// Protected range bases
	localparam logic [ADDR_W-1:0] PROT_QUARTER_BASE = 10'h300;
	localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 10'h200;

	// Internal write time: the longest time, rounded down to cycles
	localparam int T_WRITE_NS = 5000000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int WRITE_CYCLES_DFLT = T_WRITE_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 20;

	// Position of a frame within the serial sequence
	typedef enum logic [2:0] {
		PH_CMD = 3'b000,
		PH_ADDR_HI = 3'b001,
		PH_ADDR_LO = 3'b010,
		PH_DATA = 3'b011,
		PH_IGNORE = 3'b100
	} sep_phase_t;

endpackage

/* hw/sep_top.sv */
// Purpose: Slave command logic of a serial EEPROM with block and hardware write protection
// Assumes: Serial clock is the link clock; it runs only inside frames
// Notes: Link logic captures a frame; the system clock executes it at the select rise
`timescale 1ns/1ps
`default_nettype none

module sep_top #(
	parameter int WRITE_CYCLES = sep_pkg::WRITE_CYCLES_DFLT // Busy length in clocks
) (
	input wire logic ref_clk_in, // System clock, 200 MHz
	input wire logic rst_in, // Asynchronous reset, active high
	input wire logic sck_in, // Serial clock from the master
	input wire logic cs_n_in, // Chip select, active low
	input wire logic si_in, // Serial data in
	input wire logic hold_n_in, // Pause, active low
	input wire logic wp_n_in, // Write protect pin, active low
	output logic so_out, // Serial data out
	output logic so_en_n_out // Output enable of serial data, low drives
);
	import sep_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic link_rst;
	logic oe_off;
	sep_phase_t phase_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic tx_act_q;
	logic [1:0] addr_hi_q;
	logic [ADDR_W-1:0] rd_addr_q;
	logic [7:0] rx_byte;
	logic byte_done;
	logic first_bit;
	logic [7:0] stat_s1_q;
	logic [7:0] stat_s2_q;
	logic [7:0] cmd_q;
	logic aligned_q;
	logic frame_tg_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic [PAGE_BYTES-1:0] mask_q;
	logic [7:0] stat_new_q;
	logic stat_got_q;
	logic [7:0] pbuf_q [PAGE_BYTES];
	logic [7:0] mem_q [MEM_BYTES];
	logic so_q;
	logic so_en_n_q;
	logic cs_s1_q;
	logic cs_s2_q;
	logic cs_s3_q;
	logic wp_s1_q;
	logic wp_s2_q;
	logic seen_tg_q;
	logic busy_q;
	logic [CNT_W-1:0] wc_cnt_q;
	logic latch_q;
	logic hwp_en_q;
	logic [1:0] bp_q;
	logic [7:0] stat_q;
	logic cs_rise;
	logic exec;
	logic hw_prot;
	logic page_prot;
	logic start_stat;
	logic start_array;
	logic [2:0] op;

	////////////////////////////////////////////////////////////////////////////
	// Link side: frame control, cleared whenever the device is deselected

	assign link_rst = rst_in | cs_n_in;
	assign oe_off = link_rst | ~hold_n_in;
	assign rx_byte = {shift_q[6:0], si_in};
	assign byte_done = (bit_cnt_q == 3'h7);
	assign first_bit = (phase_q == PH_CMD) && (bit_cnt_q == 3'h0);

	// Bit counting, decode and read data; frozen while paused
	always_ff @(posedge sck_in or posedge link_rst) begin
		if (link_rst) begin
			phase_q <= PH_CMD;
			bit_cnt_q <= 3'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			tx_act_q <= 1'b0;
			addr_hi_q <= 2'h0;
			rd_addr_q <= '0;
		end else if (hold_n_in) begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			shift_q <= rx_byte;
			if (byte_done) begin
				case (phase_q)
					PH_CMD: begin
						// Busy lets only the status read through
						if (rx_byte[7:4] != 4'h0) begin
							phase_q <= PH_IGNORE;
						end else if (stat_s2_q[ST_BUSY] && rx_byte[2:0] != OP_STAT_RD) begin
							phase_q <= PH_IGNORE;
						end else if (rx_byte[2:0] == OP_STAT_RD) begin
							tx_q <= stat_s2_q;
							tx_act_q <= 1'b1;
							phase_q <= PH_DATA;
						end else if (rx_byte[2:0] == OP_ARRAY_RD ||
							rx_byte[2:0] == OP_ARRAY_WR) begin
							phase_q <= PH_ADDR_HI;
						end else if (rx_byte[2:0] == OP_STAT_WR) begin
							phase_q <= PH_DATA;
						end else begin
							phase_q <= PH_IGNORE;
						end
					end
					PH_ADDR_HI: begin
						addr_hi_q <= rx_byte[1:0];
						phase_q <= PH_ADDR_LO;
					end
					PH_ADDR_LO: begin
						phase_q <= PH_DATA;
						if (cmd_q[2:0] == OP_ARRAY_RD) begin
							tx_q <= mem_q[{addr_hi_q, rx_byte}];
							rd_addr_q <= {addr_hi_q, rx_byte} + 10'h001;
							tx_act_q <= 1'b1;
						end
					end
					PH_DATA: begin
						if (cmd_q[2:0] == OP_STAT_RD) begin
							tx_q <= stat_s2_q;
						end else if (cmd_q[2:0] == OP_ARRAY_RD) begin
							tx_q <= mem_q[rd_addr_q];
							rd_addr_q <= rd_addr_q + 10'h001;
						end
					end
					default: begin
						phase_q <= PH_IGNORE;
					end
				endcase
			end
		end
	end

	// Status byte into the link domain, two stages per bit; it is quasi-static
	always_ff @(posedge sck_in or posedge rst_in) begin
		if (rst_in) begin
			stat_s1_q <= 8'h00;
			stat_s2_q <= 8'h00;
		end else begin
			stat_s1_q <= stat_q;
			stat_s2_q <= stat_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link side: captured frame, kept past the select rise for execution

	// Cleared by reset and at the first bit of the next frame, never by deselect
	always_ff @(posedge sck_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_q <= 8'hff;
			aligned_q <= 1'b0;
			frame_tg_q <= 1'b0;
			wr_addr_q <= '0;
			mask_q <= '0;
			stat_new_q <= 8'h00;
			stat_got_q <= 1'b0;
		end else if (hold_n_in && !cs_n_in) begin
			aligned_q <= byte_done;
			if (first_bit) begin
				cmd_q <= 8'hff;
				frame_tg_q <= ~frame_tg_q;
				mask_q <= '0;
				stat_got_q <= 1'b0;
			end
			if (byte_done) begin
				case (phase_q)
					PH_CMD: begin
						cmd_q <= rx_byte;
					end
					PH_ADDR_LO: begin
						wr_addr_q <= {addr_hi_q, rx_byte};
					end
					PH_DATA: begin
						if (cmd_q[2:0] == OP_ARRAY_WR) begin
							mask_q[wr_addr_q[PAGE_W-1:0]] <= 1'b1;
							wr_addr_q[PAGE_W-1:0] <= wr_addr_q[PAGE_W-1:0] + 5'h01;
						end else if (cmd_q[2:0] == OP_STAT_WR) begin
							stat_new_q <= rx_byte;
							stat_got_q <= 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Page buffer; a repeated in-page offset overwrites the earlier byte
	always_ff @(posedge sck_in) begin
		if (hold_n_in && !cs_n_in && byte_done && phase_q == PH_DATA &&
			cmd_q[2:0] == OP_ARRAY_WR) begin
			pbuf_q[wr_addr_q[PAGE_W-1:0]] <= rx_byte;
		end
	end

	// Output after the falling edge; cleared when deselected, frozen while paused
	always_ff @(negedge sck_in or posedge link_rst) begin
		if (link_rst) begin
			so_en_n_q <= 1'b1;
			so_q <= 1'b0;
		end else if (hold_n_in) begin
			so_en_n_q <= ~tx_act_q;
			so_q <= tx_q[~bit_cnt_q];
		end
	end

	// Pause gates the enable directly, so the pending bit returns at resume
	// instead of being lost until the next falling edge
	assign so_out = so_q;
	assign so_en_n_out = so_en_n_q | oe_off;

	////////////////////////////////////////////////////////////////////////////
	// System side: synchronisers

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			wp_s1_q <= 1'b1;
			wp_s2_q <= 1'b1;
		end else begin
			cs_s1_q <= cs_n_in;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
			wp_s1_q <= wp_n_in;
			wp_s2_q <= wp_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// System side: execution decision at the select rise

	assign cs_rise = cs_s2_q & ~cs_s3_q;
	assign op = cmd_q[2:0];
	assign exec = cs_rise && !busy_q && aligned_q && (cmd_q[7:4] == 4'h0) &&
		(frame_tg_q != seen_tg_q);
	assign hw_prot = hwp_en_q & ~wp_s2_q;
	// Ranges are page aligned, so the whole page shares one verdict
	assign page_prot = (bp_q == 2'h3) ||
		(bp_q == 2'h2 && {wr_addr_q[ADDR_W-1:PAGE_W], 5'h00} >= PROT_HALF_BASE) ||
		(bp_q == 2'h1 && {wr_addr_q[ADDR_W-1:PAGE_W], 5'h00} >= PROT_QUARTER_BASE);
	assign start_stat = exec && op == OP_STAT_WR && latch_q && !hw_prot && stat_got_q;
	assign start_array = exec && op == OP_ARRAY_WR && latch_q && !page_prot &&
		(mask_q != '0);

	// Marks a frame as consumed so a bare select toggle is not re-executed
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			seen_tg_q <= 1'b0;
		end else if (cs_rise) begin
			seen_tg_q <= frame_tg_q;
		end
	end

	// Write latch: cleared at power-up and by every finished write
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			latch_q <= LATCH_RESET;
		end else if (busy_q && wc_cnt_q == CNT_W'(WRITE_CYCLES - 1)) begin
			latch_q <= 1'b0;
		end else if (exec && op == OP_SET_LATCH) begin
			latch_q <= 1'b1;
		end else if (exec && op == OP_CLR_LATCH) begin
			latch_q <= 1'b0;
		end
	end

	// Protection cells; the reset value stands in for the stored contents
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			hwp_en_q <= HWP_EN_RESET;
			bp_q <= BP_RESET;
		end else if (start_stat) begin
			hwp_en_q <= stat_new_q[ST_HWP_EN];
			bp_q <= {stat_new_q[ST_BP_HI], stat_new_q[ST_BP_LO]};
		end
	end

	// Self-timed write; the pin is not looked at once it runs
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			busy_q <= 1'b0;
			wc_cnt_q <= '0;
		end else if (busy_q) begin
			if (wc_cnt_q == CNT_W'(WRITE_CYCLES - 1)) begin
				busy_q <= 1'b0;
				wc_cnt_q <= '0;
			end else begin
				wc_cnt_q <= wc_cnt_q + CNT_W'(1);
			end
		end else if (start_stat || start_array) begin
			busy_q <= 1'b1;
			wc_cnt_q <= '0;
		end
	end

	// Array cells: the received bytes of the page are committed as the busy interval starts
	always_ff @(posedge ref_clk_in) begin
		for (int i = 0; i < PAGE_BYTES; i++) begin
			if (start_array && mask_q[i]) begin
				mem_q[{wr_addr_q[ADDR_W-1:PAGE_W], 5'(i)}] <= pbuf_q[i];
			end
		end
	end

	// Status byte as seen by a status read
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			stat_q <= 8'h00;
		end else if (busy_q) begin
			stat_q <= STAT_BUSY_VAL;
		end else begin
			stat_q <= {hwp_en_q, 3'h0, bp_q, latch_q, 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_busy_status: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$rose(busy_q) |=> stat_q == 8'hff)
		else $error("Status byte not all ones while busy");

	a_idle_status: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(!busy_q ##1 !busy_q) |-> (stat_q[ST_BUSY] == 1'b0 && stat_q[6:4] == 3'h0))
		else $error("Idle status shows busy or nonzero spare bits");

	a_latch_done: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$fell(busy_q) |-> !latch_q)
		else $error("Write latch still set after write cycle");

	a_busy_end: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(busy_q && wc_cnt_q == CNT_W'(WRITE_CYCLES - 1)) |=> !busy_q)
		else $error("Busy interval did not end on time");

	a_wp_no_abort: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(busy_q && wc_cnt_q < CNT_W'(WRITE_CYCLES - 1)) |=> busy_q)
		else $error("Write cycle cut short");

	a_hw_protect: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(cs_rise && hw_prot) |=> ($stable(hwp_en_q) && $stable(bp_q)))
		else $error("Status changed under hardware protection");

	a_no_latch: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(cs_rise && !busy_q && !latch_q) |=> !busy_q)
		else $error("Write started without the latch");

	a_clear_latch: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(exec && op == OP_CLR_LATCH) |=> !latch_q)
		else $error("Clear latch command ignored");

	a_busy_ignore: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(cs_rise && busy_q) |=> ($stable(bp_q) && $stable(hwp_en_q)))
		else $error("Command acted during write cycle");

	a_hold_hiz: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(!hold_n_in ##1 !hold_n_in) |-> so_en_n_out)
		else $error("Output driven while paused");

	a_deselect_hiz: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(cs_n_in ##1 cs_n_in) |-> so_en_n_q)
		else $error("Output driven while deselected");

endmodule

`default_nettype wire

/* bench/sep_master.sv */
// Purpose: Mode 0 serial master model that drives the EEPROM link
// Assumes: Link clock half period 40 ns; the clock stands low between frames
// Notes: The data line shows the inverse of its last bit when it carries nothing
`timescale 1ns/1ps
`default_nettype none

module sep_master (
	output logic sck_out, // Serial clock, still outside frames
	output logic cs_n_out, // Chip select, active low
	output logic si_out, // Serial data to the device
	output logic hold_n_out, // Pause, active low
	input wire logic so_in, // Serial data from the device
	input wire logic so_en_n_in // Output enable, low drives
);
	logic [7:0] tx_q [0:5]; // Bytes to send
	logic [15:0] rx_q; // Bytes received, first in the high byte
	int hold_bit = -1; // Bit to pause before, -1 for none
	int so_moves = 0; // Output changes seen while the clock is high
	logic hold_off_q = 1'b1; // Output stayed off in every pause

	////////////////////////////////////////////////////////////////
	// Idle levels at time zero
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
		hold_n_out = 1'b1;
	end

	// A change while the clock is high would break the master's sampling
	always @(so_in) if (sck_out && !cs_n_out) so_moves++;

	////////////////////////////////////////////////////////////////
	// Pause with the clock low, keep toggling it, resume with it low
	task automatic pause();
		#20 hold_n_out = 1'b0;
		#20;
		repeat (2) begin
			si_out = ~si_out;
			#40 sck_out = 1'b1;
			hold_off_q &= so_en_n_in;
			#40 sck_out = 1'b0;
		end
		#20 hold_n_out = 1'b1;
		#20;
	endtask

	// One frame: ntx bytes out, then nrd bytes in, MSB first
	task automatic frame(input int ntx, input int nrd);
		int i;
		#1.7 cs_n_out = 1'b0;
		#40;
		for (i = 0; i < 8 * (ntx + nrd); i++) begin
			if (i == hold_bit) pause();
			si_out = (i < 8 * ntx) ? tx_q[i / 8][7 - i % 8] : ~si_out;
			#40 sck_out = 1'b1;
			if (i >= 8 * ntx) rx_q = {rx_q[14:0], so_en_n_in ? 1'bx : so_in};
			#40 sck_out = 1'b0;
		end
		#40 cs_n_out = 1'b1;
		si_out = ~si_out;
		#100;
	endtask
endmodule

`default_nettype wire

/* bench/sep_top_tb.sv */
// Purpose: Self-checking bench for the serial EEPROM command and protection block
// Assumes: Busy interval shortened to 2 us; link clock made by the master model
// Notes: Table rows run first, then the pause and mid-run reset cases
`timescale 1ns/1ps
`default_nettype none

module sep_top_tb;
	import sep_pkg::*;
	typedef struct {
		logic [47:0] tx;
		int ntx;
		int nrd;
		logic [15:0] exp;
		logic wp;
		int gap;
	} sep_row_t;
	localparam int BUSY = 400; // Busy clocks, 2 us
	localparam int LONG = 2500; // Gap that outlasts a write
	localparam logic [7:0] LAT = 8'h01 << ST_LATCH;
	localparam logic [7:0] HWP = 8'h01 << ST_HWP_EN;
	localparam logic [7:0] BPL = 8'h01 << ST_BP_LO;
	localparam logic [7:0] BPS = (8'h01 << ST_BP_HI) | BPL;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic wp_n_in = 1'b1;
	logic sck, cs_n, si, hold_n, so_out, so_en_n_out;
	int num_errors = 0;
	int check_count = 0;
	int cyc = 0;
	sep_row_t rows[$];

	////////////////////////////////////////////////////////////////
	sep_top #(.WRITE_CYCLES(BUSY)) i_dut (
		.ref_clk_in(ref_clk_in), .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n),
		.si_in(si), .hold_n_in(hold_n), .wp_n_in(wp_n_in), .so_out(so_out),
		.so_en_n_out(so_en_n_out));
	sep_master i_m (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .hold_n_out(hold_n),
		.so_in(so_out), .so_en_n_in(so_en_n_out));

	// System clock, 200 MHz
	initial forever #2.5 ref_clk_in = ~ref_clk_in;

	// A hang is cut short well past the expected run length
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("Checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	function automatic logic [7:0] op(input logic [2:0] code, input logic b3);
		return {4'h0, b3, code};
	endfunction

	// Rows hold bytes right-justified; they are left-justified for sending
	task automatic add(input int ntx, input logic [47:0] tx, input int nrd,
		input logic [15:0] exp, input logic wp, input int gap);
		sep_row_t r;
		r = '{tx << (8 * (6 - ntx)), ntx, nrd, exp, wp, gap};
		rows.push_back(r);
	endtask

	task automatic sr(input logic [7:0] e, input logic wp, input int gap);
		add(1, op(OP_STAT_RD, 1'b0), 1, e, wp, gap);
	endtask

	task automatic cmd(input logic [2:0] c, input logic wp);
		add(1, op(c, 1'b0), 0, 0, wp, 100);
	endtask

	// Drains the table; write protect is set before the next clock edge, and the frame starts 1.7 ns after that edge
	task automatic run_rows();
		sep_row_t r;
		int j;
		while (rows.size() > 0) begin
			r = rows.pop_front();
			wp_n_in <= r.wp;
			@(posedge ref_clk_in);
			for (j = 0; j < 6; j++) i_m.tx_q[j] = r.tx[47 - 8 * j -: 8];
			i_m.frame(r.ntx, r.nrd);
			if (r.nrd > 0) check(r.nrd == 2 ? i_m.rx_q : {8'h00, i_m.rx_q[7:0]}, r.exp);
			check({15'h0, so_en_n_out}, 16'h0001);
			#(r.gap);
		end
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
		sr(8'h00, 1, 100);
		cmd(OP_SET_LATCH, 1);
		sr(LAT, 1, 100);
		cmd(OP_CLR_LATCH, 1);
		sr(8'h00, 1, 100);
		add(1, op(OP_SET_LATCH, 1'b1), 0, 0, 1, 100);
		sr(LAT, 1, 100);
		add(4, {op(OP_ARRAY_WR, 1'b0), 24'h0000d0}, 0, 0, 1, 100);
		sr(STAT_BUSY_VAL, 1, LONG);
		sr(8'h00, 1, 100);
		cmd(OP_SET_LATCH, 1);
		add(5, {op(OP_ARRAY_WR, 1'b0), 32'h03ffc1c2}, 0, 0, 1, LONG);
		add(3, {op(OP_ARRAY_RD, 1'b1), 16'h03ff}, 2, 16'hc1d0, 1, 100);
		add(3, {op(OP_ARRAY_RD, 1'b0), 16'h03e0}, 1, 16'h00c2, 1, 100);
		add(4, {op(OP_ARRAY_WR, 1'b0), 24'h000077}, 0, 0, 1, 100);
		add(3, {op(OP_ARRAY_RD, 1'b0), 16'h0000}, 1, 16'h00d0, 1, 100);
		cmd(OP_SET_LATCH, 1);
		add(4, {op(OP_ARRAY_WR, 1'b0), 24'h004033}, 0, 0, 1, 100);
		add(1, op(OP_SET_LATCH, 1'b0), 0, 0, 1, LONG);
		sr(8'h00, 1, 100);
		add(1, 8'h86, 0, 0, 1, 100);
		sr(8'h00, 1, 100);
		cmd(OP_SET_LATCH, 1);
		add(2, {op(OP_STAT_WR, 1'b1), HWP | BPS}, 0, 0, 1, LONG);
		sr(HWP | BPS, 1, 100);
		cmd(OP_SET_LATCH, 1);
		add(4, {op(OP_ARRAY_WR, 1'b0), 24'h000011}, 0, 0, 1, LONG);
		add(3, {op(OP_ARRAY_RD, 1'b0), 16'h0000}, 1, 16'h00d0, 1, 100);
		sr(HWP | BPS | LAT, 0, 100);
		add(2, {op(OP_STAT_WR, 1'b0), 8'h00}, 0, 0, 0, LONG);
		sr(HWP | BPS | LAT, 0, 100);
		add(2, {op(OP_STAT_WR, 1'b0), 8'h00}, 0, 0, 1, 100);
		sr(STAT_BUSY_VAL, 0, LONG);
		sr(8'h00, 0, 100);
		cmd(OP_SET_LATCH, 0);
		add(2, {op(OP_STAT_WR, 1'b0), BPL}, 0, 0, 0, LONG);
		sr(BPL, 0, 100);
		cmd(OP_SET_LATCH, 0);
		add(4, {op(OP_ARRAY_WR, 1'b0), 24'h03ff55}, 0, 0, 0, LONG);
		add(3, {op(OP_ARRAY_RD, 1'b0), 16'h03ff}, 1, 16'h00c1, 0, 100);
		run_rows();
		// Pause in the middle of a status byte
		i_m.hold_bit = 9;
		sr(BPL | LAT, 1, 100);
		run_rows();
		i_m.hold_bit = -1;
		check({15'h0, i_m.hold_off_q}, 16'h0001);
		// Reset in mid-run clears the latch and the protection cells
		cmd(OP_SET_LATCH, 1);
		run_rows();
		@(posedge ref_clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		check({15'h0, so_en_n_out}, 16'h0001);
		rst_in <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
		sr(8'h00, 1, 100);
		run_rows();
		check(i_m.so_moves[15:0], 16'h0000);
		complete_run();
	end
endmodule

`default_nettype wire
